/* src/stsc_scan.sv */
// standby scan control: registers, sample sequencing, cycle timing
//
// How it works
// RULE1 - only inputs with their enable bit set are scanned in standby, none after reset.
// RULE2 - scanned inputs use the standby limit, sample count and gain settings only.
// RULE3 - the accumulate bit picks sum of samples instead of their mean for comparison.
// RULE4 - software should use accumulate only for proximity, as touches overflow the count.
// RULE5 - the sample-count field selects 1 to 128 samples in powers of two, default 8.
// RULE6 - all samples of one input are taken back to back and the result updates after.
// RULE7 - the duration field sets one sample to 320us, 640us, 1.28ms or 2.56ms.
// RULE8 - the period field sets the scan period to 35, 70, 105 or 140 ms.
// RULE9 - each period starts with sampling and spends the rest in low power.
// RULE10 - if sampling outlasts the period the period is stretched to fit.
// RULE11 - the gain field selects 128x down to 1x, default 32x.
// RULE12 - the gain scales each measured delta before comparison.
// RULE13 - a touch is flagged when the delta exceeds the 7-bit limit, reset 40h.
// RULE14 - unused register bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module stsc_scan #(
	parameter int SAMPLE_CYC = stsc_pkg::SAMPLE_CYC,
	parameter int PERIOD_CYC = stsc_pkg::PERIOD_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// power state
	input wire logic standby_active,
	output logic low_power,
	// analog front end
	output logic afe_sample,
	output logic [2:0] afe_input_sel,
	input wire logic signed [stsc_pkg::DELTA_W-1:0] afe_delta,
	// results
	output logic result_valid,
	output logic [2:0] result_input,
	output logic signed [7:0] result_delta,
	output logic [5:0] standby_touch
);
	// ************************************************************
	// helpers
	// ************************************************************
	// first enabled input at or after start; bit 3 set if none
	function automatic logic [3:0] find_enabled(input logic [5:0] en, input logic [3:0] start);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 5; i >= 0; i--) begin
			if (en[i] && (4'(i) >= start)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] sample_len(input logic [1:0] code);
		return 32'(SAMPLE_CYC) << code; // RULE7
	endfunction

	function automatic logic [31:0] period_len(input logic [1:0] code);
		return 32'(PERIOD_CYC) * (32'(code) + 32'd1); // RULE8
	endfunction

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] enable_ff, nxt_enable;
	logic [7:0] config_ff, nxt_config;
	logic [7:0] gain_ff, nxt_gain;
	logic [7:0] limit_ff, nxt_limit;
	logic [7:0] rdata_ff, nxt_rdata;

	// write decode and registered read data
	always_comb begin
		nxt_enable = enable_ff;
		nxt_config = config_ff;
		nxt_gain = gain_ff;
		nxt_limit = limit_ff;
		nxt_rdata = rdata_ff;
		if (reg_wr) begin
			case (reg_addr)
				stsc_pkg::ADDR_INPUT_ENABLE: nxt_enable = reg_wdata & stsc_pkg::MASK_INPUT_ENABLE; // RULE14
				stsc_pkg::ADDR_SCAN_CONFIG: nxt_config = reg_wdata;
				stsc_pkg::ADDR_GAIN_SELECT: nxt_gain = reg_wdata & stsc_pkg::MASK_GAIN_SELECT; // RULE14
				stsc_pkg::ADDR_TOUCH_LIMIT: nxt_limit = reg_wdata & stsc_pkg::MASK_TOUCH_LIMIT; // RULE14
				default: nxt_rdata = rdata_ff;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				stsc_pkg::ADDR_INPUT_ENABLE: nxt_rdata = enable_ff;
				stsc_pkg::ADDR_SCAN_CONFIG: nxt_rdata = config_ff;
				stsc_pkg::ADDR_GAIN_SELECT: nxt_rdata = gain_ff;
				stsc_pkg::ADDR_TOUCH_LIMIT: nxt_rdata = limit_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			enable_ff <= stsc_pkg::RST_INPUT_ENABLE; // RULE1
			config_ff <= stsc_pkg::RST_SCAN_CONFIG;
			gain_ff <= stsc_pkg::RST_GAIN_SELECT;
			limit_ff <= stsc_pkg::RST_TOUCH_LIMIT;
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			enable_ff <= nxt_enable;
			config_ff <= nxt_config;
			gain_ff <= nxt_gain;
			limit_ff <= nxt_limit;
			rdata_ff <= nxt_rdata;
		end
	end

	// ************************************************************
	// settings fields
	// ************************************************************
	logic accumulate;
	logic [2:0] samples_code;
	logic [1:0] duration_code;
	logic [1:0] period_code;

	assign accumulate = config_ff[stsc_pkg::ACCUM_BIT];
	assign samples_code = config_ff[stsc_pkg::SAMPLES_LSB +: 3];
	assign duration_code = config_ff[stsc_pkg::DURATION_LSB +: 2];
	assign period_code = config_ff[stsc_pkg::PERIOD_LSB +: 2];

	// ************************************************************
	// scan sequencer
	// ************************************************************
	stsc_pkg::stsc_state_t state_ff, nxt_state;
	logic [31:0] sample_cnt_ff, nxt_sample_cnt;
	logic [31:0] period_cnt_ff, nxt_period_cnt;
	logic [7:0] taken_ff, nxt_taken;
	logic [2:0] sel_ff, nxt_sel;
	logic signed [stsc_pkg::ACC_W-1:0] acc_ff, nxt_acc;
	logic [5:0] touch_ff, nxt_touch;
	logic valid_ff, nxt_valid;
	logic signed [7:0] delta_ff, nxt_delta;
	logic [2:0] res_sel_ff, nxt_res_sel;
	logic low_ff, nxt_low;
	logic signed [stsc_pkg::ACC_W-1:0] acc_sum;
	logic signed [7:0] meas_delta;
	logic meas_touch;
	logic [3:0] first_in;
	logic [3:0] next_in;

	assign acc_sum = acc_ff + stsc_pkg::ACC_W'(afe_delta);
	assign first_in = find_enabled(enable_ff[5:0], 4'd0); // RULE1
	assign next_in = find_enabled(enable_ff[5:0], 4'(sel_ff) + 4'd1);

	// judges the sum including the sample being taken now
	stsc_measure u_measure (
		.acc(acc_sum),
		.samples_code(samples_code), // RULE2 RULE5
		.accumulate(accumulate),
		.gain_code(gain_ff[2:0]),
		.limit(limit_ff[6:0]),
		.delta(meas_delta),
		.touch(meas_touch)
	);

	// period counter keeps running through sampling, so overrun stretches the period
	always_comb begin
		nxt_state = state_ff;
		nxt_sample_cnt = sample_cnt_ff;
		nxt_period_cnt = period_cnt_ff + 32'd1;
		nxt_taken = taken_ff;
		nxt_sel = sel_ff;
		nxt_acc = acc_ff;
		nxt_touch = touch_ff;
		nxt_valid = 1'b0;
		nxt_delta = delta_ff;
		nxt_res_sel = res_sel_ff;
		nxt_low = 1'b0;
		case (state_ff)
			stsc_pkg::ST_IDLE: begin
				nxt_period_cnt = 32'd0;
				if (standby_active && !first_in[3]) begin
					nxt_state = stsc_pkg::ST_SAMPLE; // RULE9
					nxt_sel = first_in[2:0];
					nxt_sample_cnt = 32'd0;
					nxt_taken = 8'd0;
					nxt_acc = '0;
				end
			end
			stsc_pkg::ST_SAMPLE: begin
				nxt_sample_cnt = sample_cnt_ff + 32'd1;
				if (!standby_active) begin
					nxt_state = stsc_pkg::ST_IDLE;
				end else if (sample_cnt_ff + 32'd1 >= sample_len(duration_code)) begin
					nxt_sample_cnt = 32'd0;
					if (taken_ff + 8'd1 == (8'd1 << samples_code)) begin // RULE5 RULE6
						nxt_touch[sel_ff] = meas_touch; // RULE13
						nxt_valid = 1'b1;
						nxt_delta = meas_delta;
						nxt_res_sel = sel_ff;
						nxt_taken = 8'd0;
						nxt_acc = '0;
						if (next_in[3]) begin
							nxt_state = stsc_pkg::ST_REST; // RULE9
							nxt_low = 1'b1;
						end else begin
							nxt_sel = next_in[2:0]; // RULE6
						end
					end else begin
						nxt_taken = taken_ff + 8'd1;
						nxt_acc = acc_sum; // RULE6
					end
				end
			end
			stsc_pkg::ST_REST: begin
				nxt_low = 1'b1;
				if (!standby_active) begin
					nxt_state = stsc_pkg::ST_IDLE;
					nxt_low = 1'b0;
				end else if (period_cnt_ff + 32'd1 >= period_len(period_code)) begin // RULE10
					nxt_state = stsc_pkg::ST_IDLE;
					nxt_low = 1'b0;
				end
			end
			default: nxt_state = stsc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff <= stsc_pkg::ST_IDLE;
			sample_cnt_ff <= 32'd0;
			period_cnt_ff <= 32'd0;
			taken_ff <= 8'd0;
			sel_ff <= 3'd0;
			acc_ff <= '0;
			touch_ff <= 6'd0;
			valid_ff <= 1'b0;
			delta_ff <= 8'sd0;
			res_sel_ff <= 3'd0;
			low_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			sample_cnt_ff <= nxt_sample_cnt;
			period_cnt_ff <= nxt_period_cnt;
			taken_ff <= nxt_taken;
			sel_ff <= nxt_sel;
			acc_ff <= nxt_acc;
			touch_ff <= nxt_touch;
			valid_ff <= nxt_valid;
			delta_ff <= nxt_delta;
			res_sel_ff <= nxt_res_sel;
			low_ff <= nxt_low;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	logic afe_ff;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			afe_ff <= 1'b0;
		end else if (clk_en) begin
			afe_ff <= (nxt_state == stsc_pkg::ST_SAMPLE);
		end
	end

	assign reg_rdata = rdata_ff;
	assign low_power = low_ff;
	assign afe_sample = afe_ff;
	assign afe_input_sel = sel_ff;
	assign result_valid = valid_ff;
	assign result_input = res_sel_ff;
	assign result_delta = delta_ff;
	assign standby_touch = touch_ff;
endmodule
`default_nettype wire

/* pkg/stsc_pkg.sv */
// constants, register map and types of the standby touch scan block
package stsc_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_INPUT_ENABLE = 8'h40;
	localparam logic [7:0] ADDR_SCAN_CONFIG = 8'h41;
	localparam logic [7:0] ADDR_GAIN_SELECT = 8'h42;
	localparam logic [7:0] ADDR_TOUCH_LIMIT = 8'h43;

	// ************************************************************
	// reset values and writable masks
	// ************************************************************
	localparam logic [7:0] RST_INPUT_ENABLE = 8'h00;
	localparam logic [7:0] RST_SCAN_CONFIG = 8'h39;
	localparam logic [7:0] RST_GAIN_SELECT = 8'h02;
	localparam logic [7:0] RST_TOUCH_LIMIT = 8'h40;
	localparam logic [7:0] MASK_INPUT_ENABLE = 8'h3F;
	localparam logic [7:0] MASK_GAIN_SELECT = 8'h07;
	localparam logic [7:0] MASK_TOUCH_LIMIT = 8'h7F;

	// ************************************************************
	// field positions of the scan configuration
	// ************************************************************
	localparam int ACCUM_BIT = 7;
	localparam int SAMPLES_LSB = 4;
	localparam int DURATION_LSB = 2;
	localparam int PERIOD_LSB = 0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_KHZ = 40000;
	localparam int SAMPLE_TIME_US = 320;
	localparam int SCAN_PERIOD_MS = 35;
	localparam int SAMPLE_CYC = (SAMPLE_TIME_US * CLK_KHZ) / 1000;
	localparam int PERIOD_CYC = SCAN_PERIOD_MS * CLK_KHZ;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int NUM_INPUTS = 6;
	localparam int DELTA_W = 16;
	localparam int ACC_W = 24;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_REST
	} stsc_state_t;
endpackage

/* src/stsc_measure.sv */
// combines accumulated samples, scales by gain, compares to the touch limit
`timescale 1ns/1ps
`default_nettype none
module stsc_measure (
	// accumulated samples
	input wire logic signed [stsc_pkg::ACC_W-1:0] acc,
	// settings
	input wire logic [2:0] samples_code,
	input wire logic accumulate,
	input wire logic [2:0] gain_code,
	input wire logic [6:0] limit,
	// result
	output logic signed [7:0] delta,
	output logic touch
);
	logic signed [stsc_pkg::ACC_W-1:0] combined;
	logic signed [31:0] scaled;

	// mean is a power-of-two shift, so no divider is needed
	always_comb begin
		if (accumulate) begin // RULE3
			combined = acc;
		end else begin
			combined = acc >>> samples_code; // RULE3
		end
		// code 0 is 128x, code 7 is 1x
		scaled = 32'(combined) <<< (3'd7 - gain_code); // RULE11 RULE12
		// saturate like an 8-bit delta count; sums of real touches clip here
		if (scaled > 32'sd127) begin
			delta = 8'sd127;
		end else if (scaled < -32'sd128) begin
			delta = -8'sd128;
		end else begin
			delta = scaled[7:0];
		end
		touch = (delta > $signed({1'b0, limit})); // RULE13
	end
endmodule
`default_nettype wire

/* verification/stsc_afe_model.sv */
// analog front end stand-in: hands back a fixed delta per input
`timescale 1ns/1ps
`default_nettype none
module stsc_afe_model (
	// clock
	input wire logic clk_sys,
	// sample request
	input wire logic afe_sample,
	input wire logic [2:0] afe_input_sel,
	// per-input delta levels
	input wire logic signed [15:0] level [6],
	// measured delta
	output logic signed [15:0] afe_delta
);
	logic signed [15:0] last_ff = 16'h0000;
	// remember the last value driven; plain process so the start value may be given
	always @(posedge clk_sys) begin
		last_ff <= afe_delta;
	end
	// idle output flips each cycle so a stale value is never mistaken for data
	always_comb begin
		if (afe_sample && afe_input_sel < 3'd6) begin
			afe_delta = level[afe_input_sel];
		end else begin
			afe_delta = ~last_ff;
		end
	end
endmodule
`default_nettype wire

/* verification/stsc_scan_props.sv */
// checker of the standby scan ports
`timescale 1ns/1ps
`default_nettype none
module stsc_scan_props (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// scan
	input wire logic standby_active,
	input wire logic low_power,
	input wire logic afe_sample,
	input wire logic [2:0] afe_input_sel,
	input wire logic result_valid,
	input wire logic signed [7:0] result_delta,
	input wire logic [5:0] standby_touch
);
	logic [5:0] en_ff;
	logic [5:0] nxt_en;
	logic [7:0] rd_mask;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// shadow of the enable register for the sampled-input check
	always_comb begin
		nxt_en = en_ff;
		if (clk_en && reg_wr && reg_addr == 8'h40) begin
			nxt_en = reg_wdata[5:0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			en_ff <= 6'h00;
		end else begin
			en_ff <= nxt_en;
		end
	end
	// bits that may read as one, per address
	always_comb begin
		case (reg_addr)
			8'h40: rd_mask = 8'h3F;
			8'h41: rd_mask = 8'hFF;
			8'h42: rd_mask = 8'h07;
			8'h43: rd_mask = 8'h7F;
			default: rd_mask = 8'h00;
		endcase
	end
	sequence s_rd_taken;
		reg_rd && clk_en;
	endsequence
	sequence s_meas_done;
		$fell(afe_sample) && $past(standby_active);
	endsequence
	valid_one_cycle_a: assert property (result_valid |=> !result_valid)
		else $error("result valid longer than a cycle");
	valid_at_end_a: assert property (s_meas_done |-> result_valid)
		else $error("sampling ended without a result");
	sample_enabled_a: assert property (afe_sample |-> en_ff[afe_input_sel])
		else $error("disabled input sampled");
	sample_rest_excl_a: assert property (afe_sample |-> !low_power)
		else $error("low power while sampling");
	abort_idle_a: assert property (!standby_active |=> !afe_sample && !low_power)
		else $error("scan continues outside standby");
	touch_on_result_a: assert property ($changed(standby_touch) |-> result_valid)
		else $error("touch flags moved without a result");
	delta_on_result_a: assert property ($changed(result_delta) |-> result_valid)
		else $error("delta moved without a result");
	unused_zero_a: assert property (s_rd_taken |=> (reg_rdata & ~$past(rd_mask)) == 8'h00)
		else $error("unused register bits read as one");
	restart_a: assert property ($fell(low_power) && standby_active && $past(standby_active)
		&& en_ff != 6'h00 |=> afe_sample)
		else $error("next period did not start");
endmodule
bind stsc_scan stsc_scan_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
	.clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_active(standby_active),
	.low_power(low_power), .afe_sample(afe_sample), .afe_input_sel(afe_input_sel),
	.result_valid(result_valid), .result_delta(result_delta), .standby_touch(standby_touch));
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench of the standby touch scan block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, standby_active = 0, clk_en = 1;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cfg;
	logic low_power, afe_sample, result_valid;
	logic [2:0] afe_input_sel, result_input, g;
	logic signed [15:0] afe_delta;
	logic signed [15:0] lvl [6];
	logic signed [7:0] result_delta;
	logic [5:0] standby_touch, en;
	logic [6:0] lim;
	logic [15:0] r = 16'h5B3F;
	int errors = 0, samples_checked = 0, cyc_n = 0, t_rise = -1, t_last = -1, t_first = -1;
	int j = 0, k, nl, sc, mx;
	// enabled inputs of the current setting, in scan order
	int order[$];
	logic prev_smp = 0;
	logic [7:0] en_t [9] = '{8'h01, 8'h25, 8'h3F, 8'h02, 8'h12, 8'h08, 8'h10, 8'h0C, 8'h01};
	logic [7:0] cf_t [9] = '{8'h00, 8'h93, 8'h39, 8'h74, 8'h5A, 8'h0E, 8'h21, 8'hC0, 8'h60};
	logic [2:0] g_t [9] = '{3'd7, 3'd0, 3'd2, 3'd5, 3'd3, 3'd6, 3'd1, 3'd4, 3'd0};
	// shortened sample and period units keep the run small
	localparam int SMP = 4;
	localparam int PER = 100;
	stsc_scan #(.SAMPLE_CYC(SMP), .PERIOD_CYC(PER)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_active(standby_active),
		.low_power(low_power), .afe_sample(afe_sample), .afe_input_sel(afe_input_sel),
		.afe_delta(afe_delta), .result_valid(result_valid), .result_input(result_input),
		.result_delta(result_delta), .standby_touch(standby_touch));
	stsc_afe_model afe (.clk_sys(clk_sys), .afe_sample(afe_sample),
		.afe_input_sel(afe_input_sel), .level(lvl), .afe_delta(afe_delta));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected scan period: the period field, stretched when sampling outlasts it
	function automatic int span(logic [7:0] c, int n);
		int s;
		s = n * (1 << c[6:4]) * (SMP << c[3:2]);
		return (s > PER * (c[1:0] + 1)) ? s : PER * (c[1:0] + 1);
	endfunction
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys) #2;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk_sys) #2;
		reg_wr = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk_sys) #2;
		reg_addr = a;
		reg_rd = 1;
		@(posedge clk_sys) #2;
		reg_rd = 0;
		check("rdata", reg_rdata, exp);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// reference model: order, timing and value of every measurement
	always @(posedge clk_sys) begin
		cyc_n++;
		if (result_valid === 1'b1) begin
			k = order[j];
			nl = (1 << cfg[6:4]) * (SMP << cfg[3:2]);
			mx = span(cfg, order.size());
			check("input", result_input, k);
			check("low_power", low_power, j + 1 == order.size());
			if (j > 0) check("gap", cyc_n - t_last, nl);
			else if (t_rise >= 0) check("first", cyc_n - t_rise, nl);
			if (j == 0 && t_first >= 0) check("period", cyc_n - t_first <= mx + 3 && cyc_n - t_first >= mx, 1);
			sc = (1 << cfg[6:4]) * lvl[k];
			if (!cfg[7]) sc = sc >>> cfg[6:4];
			sc = sc * (1 << (7 - g));
			sc = sc > 127 ? 127 : (sc < -128 ? -128 : sc);
			check("delta", result_delta[7:0], sc[7:0]);
			check("touch", standby_touch[k], sc > int'(lim));
			t_last = cyc_n;
			if (j == 0) t_first = cyc_n;
			t_rise = -1;
			j = (j + 1 == order.size()) ? 0 : j + 1;
		end
		if (afe_sample === 1'b1 && !prev_smp) t_rise = cyc_n;
		prev_smp = afe_sample;
		if (!standby_active) begin
			j = 0;
			t_first = -1;
			t_rise = -1;
		end
	end
	// watchdog sized well above the longest config run
	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		#2 reset_n = 1;
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h39);
		rd(8'h42, 8'h02);
		rd(8'h43, 8'h40);
		for (int c = 0; c < 9; c++) begin
			en = en_t[c][5:0];
			cfg = cf_t[c];
			g = g_t[c];
			order = {};
			for (int i = 0; i < 6; i++) begin
				if (en[i]) begin
					order.push_back(i);
				end
			end
			for (int i = 0; i < 6; i++) begin
				r = lfsr(r);
				lvl[i] = $signed({{6{r[9]}}, r[9:0]}) >>> (cfg[7] ? 4 : 0);
			end
			r = lfsr(r);
			lim = r[6:0];
			wr(8'h40, {2'b11, en});
			wr(8'h41, cfg);
			wr(8'h42, {5'h1F, g});
			wr(8'h43, {1'b1, lim});
			wr(8'h44, 8'hFF);
			rd(8'h40, {2'b00, en});
			rd(8'h41, cfg);
			rd(8'h42, {5'h00, g});
			rd(8'h43, {1'b0, lim});
			rd(8'h44, 8'h00);
			standby_active = 1;
			repeat (3 * span(cfg, order.size()) + 300) @(posedge clk_sys);
			#2 standby_active = 0;
			repeat (8) @(posedge clk_sys);
			#2;
		end
		// reset in mid-measurement, then a write that a low clock enable must hold off
		standby_active = 1;
		repeat (100) @(posedge clk_sys);
		#2 reset_n = 0;
		standby_active = 0;
		repeat (2) @(posedge clk_sys);
		#2 reset_n = 1;
		clk_en = 0;
		check("low_power", low_power, 0);
		check("afe_sample", afe_sample, 0);
		check("touch", standby_touch, 0);
		wr(8'h43, 8'h11);
		clk_en = 1;
		rd(8'h43, 8'h40);
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h39);
		end_of_test();
	end
endmodule
`default_nettype wire
